// >>> hdl/pic_defs.svh
// offsets, field positions, reset values and counts of the irq controller
`ifndef PIC_DEFS_SVH
`define PIC_DEFS_SVH

// register indices; the byte address is four times the index
`define PIC_IDX_CLR0    8'hDA
`define PIC_IDX_CLR1    8'hDB
`define PIC_IDX_MSK1    8'hDF
`define PIC_IDX_MSK0    8'hE0
`define PIC_IDX_SWEN    8'hE1

// field positions
`define PIC_SWEN_BIT    0
`define PIC_GIE_BIT     0

// reset values
`define PIC_RST_BYTE    8'h00
`define PIC_RST_SRC     10'h000

// sequencing counts
`define PIC_VEC_CYCLES  4'hD
`define PIC_PRIO_STEP   8'h04

`endif

// >>> hdl/pic_pkg.sv
// types shared by the irq controller
package pic_pkg;

   typedef enum logic [2:0] {
      PIC_ST_IDLE = 3'b001,
      PIC_ST_VEC  = 3'b010,
      PIC_ST_RET  = 3'b100
   } pic_state_t;

   typedef logic [9:0] pic_src_t;

endpackage

// >>> hdl/pic_top.sv
// prioritized interrupt controller with vectoring and return sequencer
//
// Contract
// - a source event sets its posted flag.
// - posted flag holds until the vector is taken or software clears it.
// - a posted flag is pending only while its mask bit is one.
// - clearing a mask bit neither clears nor blocks posting.
// - all pending requests are encoded; taking needs global enable set.
// - the highest priority pending request supplies the vector.
// - activity follows event, mask unmasking, or global enable rising.
// - vectoring starts only after the current instruction completes.
// - vectoring lasts exactly 13 cycles up to the first table fetch.
// - push pc high byte, pc low byte, then flags, in that order.
// - vectoring clears the whole flag register, dropping global enable.
// - pc high byte zeroed, vector byte loaded into pc low byte.
// - software setting global enable re-allows vectoring at once.
// - return pops flags, pc low byte, pc high byte, restoring enable.
// - after return, pending requests vector before the next instruction.
// - fixed priority reset, supply, analog, touch ... timer 2, 0 to 10.
// - vector address is four times the priority number.
// - software may disable globally or per source and clear flags.
// - software may post any individual interrupt.
// - soft enable low: zero clears; soft enable high: one posts.
// - reading a clear register shows the posted flags.
// - mask zero masks, one unmasks; masks reset to zero.
`timescale 1ns/100ps
`include "pic_defs.svh"

module pic_top
   import pic_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [9:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic [9:0]  irq_src_i,
   input  wire logic        instr_done_i,
   input  wire logic        return_from_irq_instr_i,
   input  wire logic [15:0] pc_i,
   input  wire logic        flag_we_i,
   input  wire logic [7:0]  flag_wdata_i,
   input  wire logic [7:0]  stack_rdata_i,
   output logic      [7:0]  flags_o,
   output logic             stack_push_o,
   output logic             stack_pop_o,
   output logic      [7:0]  stack_wdata_o,
   output logic             pc_load_o,
   output logic      [15:0] pc_o,
   output logic             vec_fetch_o,
   output logic      [7:0]  vector_o,
   output logic             irq_active_o
);

   // clear/mask register 0 holds i2c at bit 7 and sleep at bit 6
   function automatic logic [7:0] swap67(input logic [7:0] b);
      swap67 = {b[6], b[7], b[5:0]};
   endfunction

   // priority number of highest pending source, zero when none
   function automatic logic [3:0] prio_enc(input pic_src_t p);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 9; i >= 0; i--) begin
         if (p[i]) begin
            r = 4'(i + 1);
         end
      end
      prio_enc = r;
   endfunction

   function automatic pic_src_t src_bit(input logic [3:0] prio);
      src_bit = (prio == 4'h0) ? `PIC_RST_SRC
                               : pic_src_t'(10'h001 << (prio - 4'h1));
   endfunction

   pic_state_t  state_r;
   logic [3:0]  cnt_r;
   pic_src_t    posted_r;
   pic_src_t    posted_nxt;
   pic_src_t    mask_r;
   logic        swen_r;
   logic [7:0]  flags_r;
   logic [15:0] pc_save_r;
   logic [7:0]  pcl_r;
   pic_src_t    pending;
   pic_src_t    sw_sel;
   pic_src_t    sw_data;
   pic_src_t    sw_set;
   pic_src_t    sw_clr;
   pic_src_t    ack_clr;
   logic [3:0]  prio;
   logic [7:0]  idx;
   logic        wr_hit;
   logic        global_irq_enable;
   logic        irq_req;
   logic        ret_done;
   logic        take;
   logic [15:0] pc_src;

   assign idx     = wb_adr_i[9:2];
   assign wr_hit  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
   assign global_irq_enable     = flags_r[`PIC_GIE_BIT];
   assign pending = posted_r & mask_r;
   assign prio    = prio_enc(pending);
   assign irq_req = (|pending) & global_irq_enable;
   assign ret_done = (state_r == PIC_ST_RET) && (cnt_r == 4'h5);
   // new vector taken after instruction end or straight after a return
   assign take = irq_req &&
                 (((state_r == PIC_ST_IDLE) && instr_done_i) ||
                  ret_done);
   assign pc_src = ret_done ? {stack_rdata_i, pcl_r} : pc_i;
   assign ack_clr = take ? src_bit(prio) : `PIC_RST_SRC;

   // software access to the clear registers
   always_comb begin
      sw_sel  = `PIC_RST_SRC;
      sw_data = `PIC_RST_SRC;
      if (idx == `PIC_IDX_CLR0) begin
         sw_sel  = 10'h0FF;
         sw_data = {2'b00, swap67(wb_dat_i[7:0])};
      end else if (idx == `PIC_IDX_CLR1) begin
         sw_sel  = 10'h300;
         sw_data = {wb_dat_i[1:0], 8'h00};
      end
   end

   assign sw_set = (wr_hit && swen_r) ? (sw_sel & sw_data)
                                      : `PIC_RST_SRC;
   assign sw_clr = (wr_hit && !swen_r) ? (sw_sel & ~sw_data)
                                       : `PIC_RST_SRC;
   // set wins over clear; mask plays no part here
   assign posted_nxt = (posted_r & ~(sw_clr | ack_clr)) |
                       irq_src_i | sw_set;

   // wishbone slave: one wait state, unmapped reads zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         wb_dat_o <= 32'h0000_0000;
         if (idx == `PIC_IDX_CLR0) begin
            wb_dat_o[7:0] <= swap67(posted_r[7:0]);
         end else if (idx == `PIC_IDX_CLR1) begin
            wb_dat_o[1:0] <= posted_r[9:8];
         end else if (idx == `PIC_IDX_MSK0) begin
            wb_dat_o[7:0] <= swap67(mask_r[7:0]);
         end else if (idx == `PIC_IDX_MSK1) begin
            wb_dat_o[1:0] <= mask_r[9:8];
         end else if (idx == `PIC_IDX_SWEN) begin
            wb_dat_o[`PIC_SWEN_BIT] <= swen_r;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         posted_r <= `PIC_RST_SRC;
      end else begin
         posted_r <= posted_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_r <= `PIC_RST_SRC;
         swen_r <= 1'b0;
      end else if (wr_hit) begin
         if (idx == `PIC_IDX_MSK0) begin
            mask_r[7:0] <= swap67(wb_dat_i[7:0]);
         end else if (idx == `PIC_IDX_MSK1) begin
            mask_r[9:8] <= wb_dat_i[1:0];
         end else if (idx == `PIC_IDX_SWEN) begin
            swen_r <= wb_dat_i[`PIC_SWEN_BIT];
         end
      end
   end

   // cpu flag register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags_r <= `PIC_RST_BYTE;
      end else if ((state_r == PIC_ST_VEC) && (cnt_r == 4'h1)) begin
         flags_r <= `PIC_RST_BYTE;
      end else if ((state_r == PIC_ST_RET) && (cnt_r == 4'h1)) begin
         flags_r <= stack_rdata_i;
      end else if (flag_we_i) begin
         flags_r <= flag_wdata_i;
      end
   end
   assign flags_o = flags_r;

   // vectoring and return sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r       <= PIC_ST_IDLE;
         cnt_r         <= 4'h0;
         pc_save_r     <= 16'h0000;
         pcl_r         <= 8'h00;
         vector_o      <= 8'h00;
         stack_push_o  <= 1'b0;
         stack_pop_o   <= 1'b0;
         stack_wdata_o <= 8'h00;
         pc_load_o     <= 1'b0;
         pc_o          <= 16'h0000;
         vec_fetch_o   <= 1'b0;
         irq_active_o  <= 1'b0;
      end else begin
         irq_active_o <= irq_req;
         stack_push_o <= 1'b0;
         stack_pop_o  <= 1'b0;
         pc_load_o    <= 1'b0;
         vec_fetch_o  <= 1'b0;
         cnt_r        <= cnt_r + 4'h1;
         if (take) begin
            state_r       <= PIC_ST_VEC;
            cnt_r         <= 4'h0;
            pc_save_r     <= pc_src;
            vector_o      <= 8'(prio * `PIC_PRIO_STEP);
            stack_push_o  <= 1'b1;
            stack_wdata_o <= pc_src[15:8];
         end else begin
            case (state_r)
               PIC_ST_IDLE: begin
                  cnt_r <= 4'h0;
                  if (return_from_irq_instr_i) begin
                     state_r     <= PIC_ST_RET;
                     stack_pop_o <= 1'b1;
                  end
               end
               PIC_ST_VEC: begin
                  if (cnt_r == 4'h0) begin
                     stack_push_o  <= 1'b1;
                     stack_wdata_o <= pc_save_r[7:0];
                  end else if (cnt_r == 4'h1) begin
                     stack_push_o  <= 1'b1;
                     stack_wdata_o <= flags_r;
                  end else if (cnt_r == (`PIC_VEC_CYCLES - 4'h2)) begin
                     state_r     <= PIC_ST_IDLE;
                     pc_load_o   <= 1'b1;
                     pc_o        <= {8'h00, vector_o};
                     vec_fetch_o <= 1'b1;
                  end
               end
               PIC_ST_RET: begin
                  if ((cnt_r == 4'h1) || (cnt_r == 4'h3)) begin
                     stack_pop_o <= 1'b1;
                  end
                  if (cnt_r == 4'h3) begin
                     pcl_r <= stack_rdata_i;
                  end
                  if (ret_done) begin
                     state_r   <= PIC_ST_IDLE;
                     pc_load_o <= 1'b1;
                     pc_o      <= {stack_rdata_i, pcl_r};
                  end
               end
               default: begin
                  state_r <= PIC_ST_IDLE;
               end
            endcase
         end
      end
   end

   // checks
   logic vec_entry;
   assign vec_entry = (state_r == PIC_ST_VEC) && (cnt_r == 4'h0);

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_src_posts: assert property (
      (|irq_src_i) |=> ((posted_r & $past(irq_src_i)) == $past(irq_src_i)))
      else $error("source event did not post");
   a_post_sticky: assert property (
      1'b1 |=> ((~posted_r & $past(posted_r) &
                 ~$past(sw_clr | ack_clr)) == 10'h000))
      else $error("posted flag dropped without a clear");
   a_take_gated: assert property (
      take |-> (global_irq_enable && ((ack_clr & mask_r & posted_r) != 10'h000)))
      else $error("vector taken without unmasked request and enable");
   a_prio_high: assert property (
      take |-> ((pending & (ack_clr - 10'h001)) == 10'h000))
      else $error("lower priority source chosen");
   a_instr_wait: assert property (
      (vec_entry && $past(state_r == PIC_ST_IDLE)) |-> $past(instr_done_i))
      else $error("vectoring began before instruction completed");
   a_vec_len: assert property (
      vec_entry |-> ##12 (vec_fetch_o && state_r == PIC_ST_IDLE))
      else $error("vectoring did not last thirteen cycles");
   a_push_order: assert property (
      vec_entry |-> (stack_push_o && stack_wdata_o == pc_save_r[15:8])
         ##1 (stack_push_o && stack_wdata_o == pc_save_r[7:0])
         ##1 (stack_push_o && flags_o == 8'h00) ##1 !stack_push_o)
      else $error("wrong push order or flags not cleared");
   a_pc_vector: assert property (
      vec_fetch_o |-> (pc_load_o && pc_o == {8'h00, vector_o} &&
                       vector_o[1:0] == 2'b00 && vector_o <= 8'h28))
      else $error("program counter not loaded with vector");
   a_ret_pops: assert property (
      (state_r == PIC_ST_IDLE && return_from_irq_instr_i && !take) |=> stack_pop_o
         ##1 !stack_pop_o ##1 stack_pop_o ##1 !stack_pop_o ##1 stack_pop_o)
      else $error("return pops out of sequence");
   a_sw_post: assert property (
      (wr_hit && idx == `PIC_IDX_CLR1 && swen_r && wb_dat_i[0])
         |=> posted_r[8])
      else $error("software post ignored");

   // request level and posting
   a_active_lvl: assert property (
      1'b1 |=> (irq_active_o == $past((|(posted_r & mask_r)) && global_irq_enable)))
      else $error("active output does not follow the request");
   a_mask_keeps: assert property (
      (wr_hit && (idx == `PIC_IDX_MSK0 || idx == `PIC_IDX_MSK1) && !take)
         |=> ((posted_r & $past(posted_r)) == $past(posted_r)))
      else $error("mask write dropped a posted flag");

   // take clears its source unless it posts again
   a_take_clears: assert property (
      take |=> ((posted_r & $past(ack_clr & ~irq_src_i & ~sw_set)) ==
                10'h000))
      else $error("taken source stayed posted");
   a_post_wins: assert property (
      (take && ((irq_src_i & ack_clr) != 10'h000))
         |=> ((posted_r & $past(ack_clr)) != 10'h000))
      else $error("same cycle post lost to the take clear");

   // return sequence and chaining
   a_ret_flags: assert property (
      (state_r == PIC_ST_RET && cnt_r == 4'h1)
         |=> (flags_o == $past(stack_rdata_i)))
      else $error("flags not restored from the stack");
   a_chain_vec: assert property (
      (ret_done && irq_req) |=> (vec_entry && !pc_load_o))
      else $error("pending request not vectored after return");

   // core flag writes and register reads
   a_gie_write: assert property (
      (state_r == PIC_ST_IDLE && flag_we_i && !take)
         |=> (flags_o == $past(flag_wdata_i)))
      else $error("core flag write lost");
   a_clr_read: assert property (
      (wb_cyc_i && wb_stb_i && !wb_ack_o && idx == `PIC_IDX_CLR1)
         |=> (wb_dat_o[1:0] == $past(posted_r[9:8])))
      else $error("clear register read does not show posted flags");

   c_vector: cover property (vec_entry ##12 vec_fetch_o);
   c_chain: cover property (ret_done && take);
   c_sw_clear: cover property (sw_clr != 10'h000);
   c_post_clash: cover property (take && ((irq_src_i & ack_clr) != 10'h000));
   c_nested: cover property ((state_r == PIC_ST_IDLE) && flag_we_i &&
                              flag_wdata_i[`PIC_GIE_BIT] && (|pending));

endmodule // pic_top

// >>> tb/pic_core_model.sv
// core-side model: stack memory and program counter
`timescale 1ns/100ps
module pic_core_model #(
   parameter logic [15:0] RST_PC = 16'hA55A
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        stack_push_i,
   input  wire logic        stack_pop_i,
   input  wire logic [7:0]  stack_wdata_i,
   input  wire logic        pc_load_i,
   input  wire logic [15:0] pc_load_val_i,
   output logic      [7:0]  stack_rdata_o,
   output logic      [15:0] pc_o
);
   logic [7:0] mem [0:31];
   logic [4:0] sp_r;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sp_r <= 5'h00;
         stack_rdata_o <= 8'h00;
      end else if (stack_push_i) begin
         mem[sp_r] <= stack_wdata_i;
         sp_r <= sp_r + 5'h01;
      end else if (stack_pop_i) begin
         stack_rdata_o <= mem[sp_r - 5'h01];
         sp_r <= sp_r - 5'h01;
      end else begin
         // stale byte is not held
         stack_rdata_o <= ~stack_rdata_o;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) pc_o <= RST_PC;
      else if (pc_load_i) pc_o <= pc_load_val_i;
   end
endmodule // pic_core_model

// >>> tb/pic_top_tb.sv
// self-checking bench of the irq controller
`timescale 1ns/100ps
`include "pic_defs.svh"
module pic_top_tb;
   import pic_pkg::*;
   logic        clk_i, rst_i, cyc, stb, we, idone, return_from_irq_instr, fwe;
   logic [9:0]  adr, src;
   logic [31:0] wdat, rdat;
   logic [7:0]  srd, flags, swd, vec, q;
   logic        ack, push, pop, pc_low_byte, vf, act;
   logic [15:0] pcc, pco;
   int          bad_count, checks, n;

   pic_top pic_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_src_i(src),
      .instr_done_i(idone), .return_from_irq_instr_i(return_from_irq_instr), .pc_i(pcc), .flag_we_i(fwe),
      .flag_wdata_i(8'h01), .stack_rdata_i(srd), .flags_o(flags),
      .stack_push_o(push), .stack_pop_o(pop), .stack_wdata_o(swd),
      .pc_load_o(pc_low_byte), .pc_o(pco), .vec_fetch_o(vf), .vector_o(vec),
      .irq_active_o(act));
   pic_core_model pic_core_model_i (.clk_i(clk_i), .rst_i(rst_i),
      .stack_push_i(push), .stack_pop_i(pop), .stack_wdata_i(swd),
      .pc_load_i(pc_low_byte), .pc_load_val_i(pco), .stack_rdata_o(srd),
      .pc_o(pcc));

   task chk(input string nm, input logic [15:0] got, input logic [15:0] e);
      checks++;
      if (got !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, got);
      end
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      wdat <= {24'h000000, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat[7:0];
      if (n >= 50) chk("ack", 16'h0000, 16'h0001);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // waits for the pc load that ends vectoring or a return
   task wait_pc;
      n = 0;
      do begin
         @(posedge clk_i);
         idone <= 1'b0;
         return_from_irq_instr <= 1'b0;
         n++;
      end while (pc_low_byte !== 1'b1 && n < 60);
   endtask
   task take;
      @(posedge clk_i);
      idone <= 1'b1;
      wait_pc;
   endtask
   task ret;
      @(posedge clk_i);
      return_from_irq_instr <= 1'b1;
      wait_pc;
   endtask
   task setgie;
      @(posedge clk_i);
      fwe <= 1'b1;
      @(posedge clk_i);
      fwe <= 1'b0;
   endtask

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   initial begin
      #(40 * 8000);
      bad_count++;
      end_of_test;
   end
   initial begin
      rst_i = 1'b1;
      {cyc, stb, we, idone, return_from_irq_instr, fwe} = 6'h00;
      adr = 10'h000;
      wdat = 32'h00000000;
      src = 10'h000;
      bad_count = 0;
      checks = 0;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, `PIC_IDX_MSK0, 8'h00);
      chk("msk0", q, 8'h00);
      wb(1'b0, `PIC_IDX_SWEN, 8'h00);
      chk("swen", q, 8'h00);
      chk("flags", flags, 8'h00);
      @(posedge clk_i);
      src <= 10'h012;
      @(posedge clk_i);
      src <= 10'h000;
      setgie;
      wb(1'b0, `PIC_IDX_CLR0, 8'h00);
      chk("posted", q, 8'h12);
      chk("masked", act, 1'b0);
      wb(1'b1, `PIC_IDX_CLR0, 8'hFF);
      wb(1'b0, `PIC_IDX_CLR0, 8'h00);
      chk("ones kept", q, 8'h12);
      wb(1'b1, `PIC_IDX_CLR0, 8'hEF);
      wb(1'b0, `PIC_IDX_CLR0, 8'h00);
      chk("zero clr", q, 8'h02);
      wb(1'b1, `PIC_IDX_SWEN, 8'h01);
      wb(1'b1, `PIC_IDX_CLR0, 8'h10);
      wb(1'b0, `PIC_IDX_CLR0, 8'h00);
      chk("soft post", q, 8'h12);
      wb(1'b1, `PIC_IDX_CLR0, 8'h00);
      wb(1'b0, `PIC_IDX_CLR0, 8'h00);
      chk("zeros kept", q, 8'h12);
      wb(1'b1, `PIC_IDX_SWEN, 8'h00);
      // flags at register bits 1 and 4 are still posted when unmasking below
      wb(1'b1, `PIC_IDX_MSK1, 8'h03);
      wb(1'b1, `PIC_IDX_MSK0, 8'hFF);
      repeat (2) @(posedge clk_i);
      chk("active", act, 1'b1);
      take;
      chk("vec cycles", n, 16'd14);
      chk("fetch", vf, 1'b1);
      chk("vector", vec, 8'h08);
      chk("pc", pco, 16'h0008);
      chk("flags clr", flags, 8'h00);
      chk("push pch", pic_core_model_i.mem[0], 8'hA5);
      chk("push pcl", pic_core_model_i.mem[1], 8'h5A);
      chk("push flg", pic_core_model_i.mem[2], 8'h01);
      wb(1'b0, `PIC_IDX_CLR0, 8'h00);
      chk("taken clr", q, 8'h10);
      ret;
      chk("next vec", vec, 8'h14);
      ret;
      chk("ret pc", pco, 16'hA55A);
      chk("ret gie", flags, 8'h01);
      chk("no fetch", vf, 1'b0);
      wb(1'b1, `PIC_IDX_SWEN, 8'h01);
      for (int i = 0; i < 10; i++) begin
         if (i < 8) wb(1'b1, `PIC_IDX_CLR0, 8'h01 << i);
         else wb(1'b1, `PIC_IDX_CLR1, 8'h01 << (i - 8));
         take;
         // register bit 6 is the sleep source, bit 7 the i2c source
         chk("table vec", vec, (i == 6) ? 8'h20 : (i == 7) ? 8'h1C
                              : 8'h04 * (i + 1));
         setgie;
      end
      wb(1'b1, 8'h00, 8'hFF);
      wb(1'b0, 8'h00, 8'h00);
      chk("unmapped", q, 8'h00);
      end_of_test;
   end
endmodule // pic_top_tb
